// ===== hw/supply_fault_pkg.sv
package supply_fault_pkg;
  // Register map
  localparam logic [7:0] UV_LIMIT_OFFSET = 8'h34;
  localparam logic [7:0] LINE_IMP_OFFSET = 8'h35;
  localparam logic [7:0] UV_LIMIT_RESET = 8'h00;
  localparam logic [7:0] LINE_IMP_RESET = 8'h00;
  // Field positions in the undervoltage limit register
  localparam int EOC_SHUTDOWN_BIT = 7;
  localparam int UV_SETTING_MSB = 6;
  localparam int UV_SETTING_STEPS = 128;
  // Line impedance flag position in the flag word
  localparam int LINE_IMP_FLAG_BIT = 2;
  // Overvoltage averaging period
  localparam int CLK_MHZ = 10;
  localparam int OVP_PERIOD_US = 80;
  localparam int OVP_PERIOD_CYCLES = OVP_PERIOD_US * CLK_MHZ;
  localparam logic [2:0] OVP_MAX_SAMPLES = 3'h4;
  // Shutdown sequencing
  typedef enum logic [1:0] {
    SD_RUN = 2'b00,
    SD_WAIT_EOC = 2'b01,
    SD_STOPPED = 2'b10
  } shutdown_e;
endpackage

// ===== hw/ovp_qualifier.sv
`timescale 1ns/1ps
module ovp_qualifier #(
  parameter int DW = 12,
  parameter int PERIOD = supply_fault_pkg::OVP_PERIOD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [DW-1:0] sampleData,
  input wire logic [DW-1:0] ovpThreshold,
  input wire logic [1:0] ovpSampling,
  output logic ovpFlag_ff
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam int SW = DW + CW;

  logic [CW-1:0] tick_ff;
  logic [CW-1:0] cnt_ff;
  logic [SW-1:0] sum_ff;
  logic [2:0] overCnt_ff;
  logic periodEnd;
  logic above;
  logic [2:0] need;
  logic [2:0] nxt_overCnt;

  // ==========================================================
  // Averaging period
  assign periodEnd = (tick_ff == CW'(PERIOD - 1));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tick_ff <= '0;
    else if (periodEnd)
      tick_ff <= '0;
    else
      tick_ff <= tick_ff + 1'b1;
  end

  // Sum and count are compared as sum > thr*count, avoiding a divider
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sum_ff <= '0;
      cnt_ff <= '0;
    end
    else if (periodEnd)
    begin
      sum_ff <= '0;
      cnt_ff <= '0;
    end
    else if (sampleValid)
    begin
      sum_ff <= sum_ff + SW'(sampleData);
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign above = (cnt_ff != '0) && (sum_ff > SW'(ovpThreshold) * SW'(cnt_ff));

  // ==========================================================
  // Consecutive period qualification
  assign need = {1'b0, ovpSampling} + 3'h1;
  assign nxt_overCnt = (overCnt_ff == supply_fault_pkg::OVP_MAX_SAMPLES) ?
    overCnt_ff : overCnt_ff + 3'h1;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      overCnt_ff <= '0;
      ovpFlag_ff <= 1'b0;
    end
    else if (periodEnd)
    begin
      overCnt_ff <= above ? nxt_overCnt : 3'h0;
      ovpFlag_ff <= above && (nxt_overCnt >= need);
    end
  end
endmodule

// ===== hw/supply_fault_limit_checker.sv
`timescale 1ns/1ps
module supply_fault_limit_checker #(
  parameter int DW = 12,
  parameter logic [DW-1:0] FULL_SCALE_CODE = 12'hfff
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData_ff,
  input wire logic ovpSampleValid,
  input wire logic [DW-1:0] ovpSampleData,
  input wire logic [DW-1:0] ovpThreshold,
  input wire logic [1:0] ovpSampling,
  input wire logic [DW-1:0] localSenseReading,
  input wire logic [7:0] lineImpedanceValue,
  input wire logic faultShutdown,
  input wire logic auxRegulating,
  input wire logic switchCycleEnd,
  output logic overvoltageFlag_ff,
  output logic undervoltageFlag_ff,
  output logic [7:0] flagWord_ff,
  output logic auxPwmStop_ff,
  output logic mainPwmStop_ff
);
  localparam int PW = DW + 8;

  logic [7:0] uvLimit_ff;
  logic [7:0] lineImpLimit_ff;
  logic [7:0] nxt_rdData;
  logic [7:0] nxt_flagWord;
  logic uvWrite;
  logic lineImpWrite;
  logic ovpRaw;
  logic [supply_fault_pkg::UV_SETTING_MSB:0] uvSetting;
  logic [PW-1:0] readingScaled;
  logic [PW-1:0] thresholdScaled;
  logic eocEnable;
  logic eocActive;
  supply_fault_pkg::shutdown_e sdState_ff;
  supply_fault_pkg::shutdown_e nxt_sdState;

  // ==========================================================
  // Registers
  // Writes to any other offset are dropped here
  assign uvWrite = regWrEn && (regAddr == supply_fault_pkg::UV_LIMIT_OFFSET);
  assign lineImpWrite = regWrEn && (regAddr == supply_fault_pkg::LINE_IMP_OFFSET);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      uvLimit_ff <= supply_fault_pkg::UV_LIMIT_RESET;
    else if (uvWrite)
      uvLimit_ff <= regWrData;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lineImpLimit_ff <= supply_fault_pkg::LINE_IMP_RESET;
    else if (lineImpWrite)
      lineImpLimit_ff <= regWrData;
  end

  // ==========================================================
  // Register read
  // Read data lags the address by one cycle; unmapped offsets read zero
  always_comb
  begin
    case (regAddr)
      supply_fault_pkg::UV_LIMIT_OFFSET:
        nxt_rdData = uvLimit_ff;
      supply_fault_pkg::LINE_IMP_OFFSET:
        nxt_rdData = lineImpLimit_ff;
      default:
        nxt_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      regRdData_ff <= 8'h00;
    else
      regRdData_ff <= nxt_rdData;
  end

  // ==========================================================
  // Overvoltage qualification
  ovp_qualifier #(
    .DW(DW),
    .PERIOD(supply_fault_pkg::OVP_PERIOD_CYCLES)
  ) u_ovp (
    .sys_clk(sys_clk),
    .rst(rst),
    .sampleValid(ovpSampleValid),
    .sampleData(ovpSampleData),
    .ovpThreshold(ovpThreshold),
    .ovpSampling(ovpSampling),
    .ovpFlag_ff(ovpRaw)
  );

  // One more stage so every flag leaves a flip-flop owned by this module
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      overvoltageFlag_ff <= 1'b0;
    else
      overvoltageFlag_ff <= ovpRaw;
  end

  // ==========================================================
  // Local sense undervoltage
  // Compare reading*128 against setting*full-scale so no divider is needed
  assign uvSetting = uvLimit_ff[supply_fault_pkg::UV_SETTING_MSB:0];
  assign readingScaled = PW'(localSenseReading) * PW'(supply_fault_pkg::UV_SETTING_STEPS);
  assign thresholdScaled = PW'(uvSetting) * PW'(FULL_SCALE_CODE);

  // Strict compare: a reading exactly on the threshold is not yet a fault
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      undervoltageFlag_ff <= 1'b0;
    else
      undervoltageFlag_ff <= (readingScaled < thresholdScaled);
  end

  // ==========================================================
  // Line impedance flag
  // Only bit 2 is owned here; the rest of the flag word reads zero
  always_comb
  begin
    nxt_flagWord = 8'h00;
    nxt_flagWord[supply_fault_pkg::LINE_IMP_FLAG_BIT] =
      (lineImpedanceValue > lineImpLimit_ff);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      flagWord_ff <= 8'h00;
    else
      flagWord_ff <= nxt_flagWord;
  end

  // ==========================================================
  // Shutdown sequencing
  assign eocEnable = uvLimit_ff[supply_fault_pkg::EOC_SHUTDOWN_BIT];
  assign eocActive = eocEnable && auxRegulating;

  always_comb
  begin
    nxt_sdState = sdState_ff;
    case (sdState_ff)
      supply_fault_pkg::SD_RUN:
      begin
        if (faultShutdown)
        begin
          if (eocActive && !switchCycleEnd)
            nxt_sdState = supply_fault_pkg::SD_WAIT_EOC;
          else
            nxt_sdState = supply_fault_pkg::SD_STOPPED;
        end
      end
      // A fault that clears while waiting still completes the stop
      supply_fault_pkg::SD_WAIT_EOC:
      begin
        if (switchCycleEnd)
          nxt_sdState = supply_fault_pkg::SD_STOPPED;
        else if (!eocActive)
          nxt_sdState = supply_fault_pkg::SD_STOPPED;
      end
      supply_fault_pkg::SD_STOPPED:
      begin
        if (!faultShutdown)
          nxt_sdState = supply_fault_pkg::SD_RUN;
      end
      // Unused state code falls to stopped, the safe side
      default:
      begin
        nxt_sdState = supply_fault_pkg::SD_STOPPED;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sdState_ff <= supply_fault_pkg::SD_RUN;
    else
      sdState_ff <= nxt_sdState;
  end

  // Stops follow the next state so a fault shows at the very next edge
  // Aux stop also takes the raw fault, so it never waits on the state register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      auxPwmStop_ff <= 1'b0;
    else
      auxPwmStop_ff <= faultShutdown || (nxt_sdState != supply_fault_pkg::SD_RUN);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mainPwmStop_ff <= 1'b0;
    else
      mainPwmStop_ff <= (nxt_sdState == supply_fault_pkg::SD_STOPPED);
  end
endmodule

// ===== test/fault_limit_properties.sv
`timescale 1ns/1ps
// ==========
// Shutdown and limit checks
module fault_limit_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData_ff,
  input wire logic [7:0] lineImpedanceValue,
  input wire logic faultShutdown,
  input wire logic auxRegulating,
  input wire logic switchCycleEnd,
  input wire logic [7:0] flagWord_ff,
  input wire logic auxPwmStop_ff,
  input wire logic mainPwmStop_ff
);
  logic [7:0] uvLim_ff;
  logic [7:0] lineLim_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadows of the limits, so no check needs a view inside the block
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      uvLim_ff <= 8'h00;
    else if (regWrEn && regAddr == 8'h34)
      uvLim_ff <= regWrData;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      lineLim_ff <= 8'h00;
    else if (regWrEn && regAddr == 8'h35)
      lineLim_ff <= regWrData;
  sequence eocWait;
    faultShutdown && uvLim_ff[7] && auxRegulating && !switchCycleEnd;
  endsequence
  a_aux_stop: assert property (faultShutdown |=> auxPwmStop_ff)
    else $error("aux stop late");
  a_main_now: assert property (faultShutdown && !(uvLim_ff[7] && auxRegulating)
    |=> mainPwmStop_ff)
    else $error("main stop late");
  a_main_wait: assert property (eocWait ##0 !mainPwmStop_ff |=> !mainPwmStop_ff)
    else $error("main stop early");
  a_main_end: assert property (faultShutdown && switchCycleEnd |=> mainPwmStop_ff)
    else $error("main stop missed cycle end");
  a_main_free: assert property (mainPwmStop_ff && !faultShutdown |=> !mainPwmStop_ff)
    else $error("main stop stuck");
  a_line_flag: assert property (!$past(rst) |->
    flagWord_ff[2] == ($past(lineImpedanceValue) > $past(lineLim_ff)))
    else $error("line flag wrong");
  a_flag_quiet: assert property (flagWord_ff[7:3] == 5'h0 && flagWord_ff[1:0] == 2'h0)
    else $error("spare flag set");
  a_read_back: assert property (regRdData_ff ==
    ($past(regAddr) == 8'h34 ? $past(uvLim_ff) :
    $past(regAddr) == 8'h35 ? $past(lineLim_ff) : 8'h00))
    else $error("read data wrong");
endmodule
bind supply_fault_limit_checker fault_limit_properties u_props (.sys_clk, .rst, .regWrEn,
  .regAddr, .regWrData, .regRdData_ff, .lineImpedanceValue, .faultShutdown,
  .auxRegulating, .switchCycleEnd, .flagWord_ff, .auxPwmStop_ff, .mainPwmStop_ff);

// ===== test/test_supply_fault_limit_checker.sv
`timescale 1ns/1ps
// ==========
// Bench
module test_supply_fault_limit_checker;
  logic sys_clk, rst, regWrEn, ovpSampleValid, faultShutdown, auxRegulating, switchCycleEnd;
  logic overvoltageFlag_ff, undervoltageFlag_ff, auxPwmStop_ff, mainPwmStop_ff;
  logic [7:0] regAddr, regWrData, regRdData_ff, lineImpedanceValue, flagWord_ff;
  logic [11:0] ovpSampleData, localSenseReading, ovpThreshold;
  logic [1:0] ovpSampling;
  int errors, tests_run, cyc, r;
  int uvSet[4] = '{0, 'h42, 'h52, 'h7f};
  supply_fault_limit_checker u_dut (.sys_clk, .rst, .regWrEn, .regAddr, .regWrData,
    .regRdData_ff, .ovpSampleValid, .ovpSampleData, .ovpThreshold, .ovpSampling,
    .localSenseReading, .lineImpedanceValue, .faultShutdown, .auxRegulating,
    .switchCycleEnd, .overvoltageFlag_ff, .undervoltageFlag_ff, .flagWord_ff,
    .auxPwmStop_ff, .mainPwmStop_ff);
  initial
  begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Cycle count since release, for the fixed averaging period boundaries
  always @(posedge sys_clk) cyc <= rst ? 0 : cyc + 1;
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  // Lands just after the fifth edge past the end of averaging period p
  task to_period(input int p);
    step(supply_fault_pkg::OVP_PERIOD_CYCLES * p + 5 - cyc);
  endtask
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1;
    step(1);
    regWrEn = 0;
    step(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    step(1);
    chk(regRdData_ff, e);
  endtask
  task end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task fault(input logic f);
    faultShutdown = f;
    step(1);
  endtask
  initial
  begin
    {rst, regWrEn, faultShutdown, auxRegulating, switchCycleEnd} = 5'h10;
    {regAddr, regWrData, lineImpedanceValue, localSenseReading} = 36'h0;
    {errors, tests_run} = 0;
    ovpSampleValid = 1;
    ovpSampleData = 12'h200;
    ovpThreshold = 12'h100;
    ovpSampling = 2'h1;
    step(10);
    rst = 0;
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h00);
    wr(8'h35, 8'h80);
    wr(8'h36, 8'hff);
    rd(8'h35, 8'h80);
    rd(8'h36, 8'h00);
    rd(8'h34, 8'h00);
    lineImpedanceValue = 8'h80;
    step(2);
    chk(flagWord_ff, 8'h00);
    lineImpedanceValue = 8'h81;
    step(2);
    chk(flagWord_ff, 8'h04);
    foreach (uvSet[i])
    begin
      wr(8'h34, 8'(uvSet[i]));
      for (int k = 0; k < 2; k++)
      begin
        r = uvSet[i] * 4095 / 128 + k;
        localSenseReading = r[11:0];
        step(2);
        chk(undervoltageFlag_ff, 12'(r * 128 < uvSet[i] * 4095));
      end
    end
    auxRegulating = 1;
    fault(1);
    chk({auxPwmStop_ff, mainPwmStop_ff}, 3);
    fault(0);
    wr(8'h34, 8'h80);
    fault(1);
    step(2);
    chk({auxPwmStop_ff, mainPwmStop_ff}, 2);
    switchCycleEnd = 1;
    step(1);
    switchCycleEnd = 0;
    chk(mainPwmStop_ff, 1);
    fault(0);
    step(1);
    auxRegulating = 0;
    fault(1);
    chk(mainPwmStop_ff, 1);
    fault(0);
    auxRegulating = 1;
    fault(1);
    chk(mainPwmStop_ff, 0);
    auxRegulating = 0;
    step(1);
    chk(mainPwmStop_ff, 1);
    fault(0);
    to_period(1);
    chk(overvoltageFlag_ff, 0);
    to_period(2);
    chk(overvoltageFlag_ff, 1);
    ovpSampleData = 12'h000;
    to_period(3);
    chk(overvoltageFlag_ff, 0);
    ovpSampleData = 12'h200;
    ovpSampling = 2'h0;
    to_period(4);
    chk(overvoltageFlag_ff, 1);
    ovpSampling = 2'h3;
    to_period(6);
    chk(overvoltageFlag_ff, 0);
    to_period(7);
    chk(overvoltageFlag_ff, 1);
    ovpThreshold = 12'h200;
    to_period(8);
    chk(overvoltageFlag_ff, 0);
    ovpThreshold = 12'h1ff;
    ovpSampling = 2'h2;
    to_period(10);
    chk(overvoltageFlag_ff, 0);
    to_period(11);
    chk(overvoltageFlag_ff, 1);
    ovpSampleValid = 0;
    ovpSampling = 2'h0;
    to_period(12);
    chk(overvoltageFlag_ff, 1);
    to_period(13);
    chk(overvoltageFlag_ff, 0);
    end_sim;
  end
endmodule
